//--- hdl/ump_pkg.sv
// Purpose: constants for the modem-pin and receiver DMA signalling block
// Assumes: AHB-Lite register access, one 200 MHz clock
// Notes: register offsets are byte addresses of aligned words
// Behaviour
// R1 - Each user output is driven low while its control bit is set.
// R2 - User outputs go high on reset, in loop mode, or when bit cleared.
// R3 - Receiver timed by a sixteen-times baud clock input from outside.
// R4 - Selected chip reads the addressed register on either read strobe.
// R5 - Host holds the unused read strobe inactive.
// R6 - Status bit 6 shows the current ring indicator condition.
// R7 - Status bit 2 sets on ring indicator rising since last read.
// R8 - Enabled modem status interrupt fires on that ring transition.
// R9 - Request-to-send follows control bit 1; high on reset or loop mode.
// R10 - Auto request-to-send mode deasserts request-to-send at receiver threshold.
// R11 - In FIFO mode, control bit 3 chooses the receiver DMA signalling type.
// R12 - Without FIFOs only DMA mode 0 is used.
// R13 - Mode 0: request low while any character held, high when none.
// R14 - Mode 1: low at trigger or time-out, high when all empty. The code has no time-out input and goes low on the trigger only.
// R15 - Mode 1 drains continuously; mode 0 is single transfer.
// R16 - Driver-disable output is high whenever the processor is not reading.
// R17 - Reading modem status clears the ring trailing-edge flag.
package ump_pkg;
   localparam logic [7:0] ADDR_MCTL = 8'h00;
   localparam logic [7:0] ADDR_FCR = 8'h04;
   localparam logic [7:0] ADDR_MSR = 8'h08;
   localparam logic [7:0] ADDR_IST = 8'h0C;
   localparam logic [7:0] ADDR_ICLR = 8'h10;
   localparam logic [7:0] ADDR_IEN = 8'h14;
   localparam logic [7:0] ADDR_PIN = 8'h18;
   // Field positions
   localparam int MCTL_RTS = 1;
   localparam int MCTL_USER1 = 2;
   localparam int MCTL_USER2 = 3;
   localparam int MCTL_LOOP = 4;
   localparam int MCTL_AUTO = 5;
   localparam int FCR_EN = 0;
   localparam int FCR_DMA = 3;
   localparam int MSR_RING_END = 2;
   localparam int MSR_RING = 6;
   localparam int IST_MSI = 0;
   localparam int IST_DMA = 1;
   localparam logic [7:0] MCTL_RST = 8'h00;
   localparam logic [7:0] FCR_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam int RCLK_SYNC = 2;
   localparam logic [31:0] UNMAPPED = 32'h0000_0000;
endpackage

//--- hdl/ump_sync.sv
// Purpose: two-flop synchroniser for slow external levels
// Assumes: input asynchronous to hclk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module ump_sync (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic d,
   output logic q
);
   logic meta_r;
   // Reset value is high, the idle level of the active-low modem pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= 1'b1;
         q <= 1'b1;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- hdl/ump_top.sv
// Purpose: modem outputs, ring status and receiver DMA request logic
// Assumes: receiver FIFO status arrives as levels on hclk
// Notes: AHB-Lite slave with zero wait states
`timescale 1ns/1ps
`default_nettype none
module ump_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic chip_select,
   input wire logic read_strobe_low_active,
   input wire logic read_strobe_high_active,
   input wire logic [2:0] pin_addr,
   output logic [7:0] pin_rdata,
   output logic driver_disable_output,
   input wire logic ring_indicator_n,
   input wire logic rx_clk16,
   input wire logic rx_char_held,
   input wire logic rx_trigger_hit,
   input wire logic rx_threshold_hit,
   output logic user_output_one_n,
   output logic user_output_two_n,
   output logic rts_n,
   output logic receiver_dma_request_n,
   output logic irq
);
   logic [7:0] modem_control_register_r;
   logic [7:0] fcr_r;
   logic ring_trailing_edge_flag_r;
   logic ring_prev_r;
   logic [1:0] ist_r;
   logic [1:0] ien_r;
   logic dma_req_r;
   logic ap_valid_r;
   logic ap_write_r;
   logic [7:0] ap_addr_r;
   logic ring_s;
   logic rclk_s;
   logic rclk_prev_r;
   logic [31:0] hrdata_r;
   logic [7:0] pin_rdata_r;
   logic drv_dis_r;

   typedef enum logic [1:0] {UMP_IDLE = 2'b01, UMP_ACTIVE = 2'b10} ump_dma_t;
   ump_dma_t dma_st_r;
   ump_dma_t dma_st_nxt;

   // Synchronise the ring indicator and the receiver 16x clock
   ump_sync u_ring (.hclk(hclk), .hresetn(hresetn), .d(ring_indicator_n), .q(ring_s));
   ump_sync u_rclk (.hclk(hclk), .hresetn(hresetn), .d(rx_clk16), .q(rclk_s));

   // Receiver timing tick, one pulse per rising 16x edge
   wire rx_tick = rclk_s && !rclk_prev_r; // [R3]

   // Bus decode
   wire ahb_start = hsel && hready && htrans[1];
   wire wr_go = ap_valid_r && ap_write_r;
   wire rd_msr_ahb = ahb_start && !hwrite && (haddr[7:0] == ump_pkg::ADDR_MSR);
   wire pin_read = chip_select && (!read_strobe_low_active || read_strobe_high_active); // [R4]
   wire rd_msr_pin = pin_read && ({pin_addr, 3'b000} == ump_pkg::ADDR_MSR[5:0]);
   wire msr_read = rd_msr_ahb || rd_msr_pin;

   // Modem control fields; loop mode forces the pins inactive
   wire loop_on = modem_control_register_r[ump_pkg::MCTL_LOOP];
   wire auto_rts = modem_control_register_r[ump_pkg::MCTL_AUTO] && fcr_r[ump_pkg::FCR_EN];
   wire fifo_on = fcr_r[ump_pkg::FCR_EN];
   wire mode1 = fifo_on && fcr_r[ump_pkg::FCR_DMA]; // [R11] [R12]

   // Ring indicator: pin is active low, so low-to-high means ring ended
   wire ring_rise = ring_s && !ring_prev_r; // [R7]
   wire [7:0] msr_val = {1'b0, !ring_s, 3'b000, ring_trailing_edge_flag_r, 2'b00}; // [R6]

   // Pin and interrupt outputs, combinational on register state and the receiver threshold input
   assign user_output_one_n = !(modem_control_register_r[ump_pkg::MCTL_USER1] && !loop_on); // [R1] [R2]
   assign user_output_two_n = !(modem_control_register_r[ump_pkg::MCTL_USER2] && !loop_on); // [R1] [R2]
   assign rts_n = !(modem_control_register_r[ump_pkg::MCTL_RTS] && !loop_on
                    && !(auto_rts && rx_threshold_hit)); // [R9] [R10]
   assign irq = |(ist_r & ien_r); // [R8]
   assign receiver_dma_request_n = !dma_req_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign pin_rdata = pin_rdata_r;
   assign driver_disable_output = drv_dis_r; // [R16]

   // Read mux shared by both ports
   function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic [7:0] mctl,
                                         input logic [7:0] fcr, input logic [7:0] msr,
                                         input logic [1:0] ist, input logic [1:0] ien);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ump_pkg::ADDR_MCTL: v = mctl;
         ump_pkg::ADDR_FCR: v = fcr;
         ump_pkg::ADDR_MSR: v = msr;
         ump_pkg::ADDR_IST: v = {6'h00, ist};
         ump_pkg::ADDR_IEN: v = {6'h00, ien};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   wire [7:0] ahb_rd = rd_mux(haddr[7:0], modem_control_register_r, fcr_r, msr_val, ist_r, ien_r);
   wire [7:0] pin_rd = rd_mux({2'b00, pin_addr, 3'b000}, modem_control_register_r, fcr_r,
                              msr_val, ist_r, ien_r);

   // DMA request state machine: mode 0 follows the character level, mode 1
   // waits for the trigger level only and then holds until fully drained
   always_comb begin
      dma_st_nxt = dma_st_r;
      case (dma_st_r)
         UMP_IDLE: begin
            if (mode1 ? rx_trigger_hit : rx_char_held) begin
               dma_st_nxt = UMP_ACTIVE; // [R13] [R14]
            end
         end
         UMP_ACTIVE: begin
            if (!rx_char_held) begin
               dma_st_nxt = UMP_IDLE; // [R13] [R14] [R15]
            end
         end
         default: dma_st_nxt = UMP_IDLE;
      endcase
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h00;
      end else begin
         ap_valid_r <= ahb_start;
         ap_write_r <= hwrite;
         ap_addr_r <= haddr[7:0];
      end
   end

   // Control registers written in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         modem_control_register_r <= ump_pkg::MCTL_RST; // [R2] [R9]
         fcr_r <= ump_pkg::FCR_RST;
         ien_r <= ump_pkg::IRQ_RST;
      end else if (wr_go) begin
         if (ap_addr_r == ump_pkg::ADDR_MCTL) modem_control_register_r <= hwdata[7:0];
         if (ap_addr_r == ump_pkg::ADDR_FCR) fcr_r <= hwdata[7:0];
         if (ap_addr_r == ump_pkg::ADDR_IEN) ien_r <= hwdata[1:0];
      end
   end

   // Ring flag and interrupt status; a new event wins over a clear
   wire [1:0] ist_clr = (wr_go && ap_addr_r == ump_pkg::ADDR_ICLR) ? hwdata[1:0] : 2'h0;
   wire dma_rise = (dma_st_nxt == UMP_ACTIVE) && (dma_st_r == UMP_IDLE);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ring_trailing_edge_flag_r <= 1'b0;
         ring_prev_r <= 1'b1;
         ist_r <= ump_pkg::IRQ_RST;
         rclk_prev_r <= 1'b1;
      end else begin
         ring_prev_r <= ring_s;
         rclk_prev_r <= rclk_s;
         ring_trailing_edge_flag_r <= ring_rise || (ring_trailing_edge_flag_r && !msr_read); // [R7] [R17]
         ist_r[ump_pkg::IST_MSI] <= ring_rise || (ist_r[ump_pkg::IST_MSI] && !ist_clr[ump_pkg::IST_MSI]); // [R8]
         ist_r[ump_pkg::IST_DMA] <= dma_rise || (ist_r[ump_pkg::IST_DMA] && !ist_clr[ump_pkg::IST_DMA]);
      end
   end

   // DMA state, read data and driver disable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_st_r <= UMP_IDLE;
         dma_req_r <= 1'b0;
         hrdata_r <= ump_pkg::UNMAPPED;
         pin_rdata_r <= 8'h00;
         drv_dis_r <= 1'b1;
      end else begin
         dma_st_r <= dma_st_nxt;
         dma_req_r <= (dma_st_nxt == UMP_ACTIVE);
         if (ahb_start && !hwrite) hrdata_r <= {24'h000000, ahb_rd}; // [R4]
         if (pin_read) pin_rdata_r <= pin_rd; // [R4]
         drv_dis_r <= !pin_read; // [R16]
      end
   end

   // Checks
   // Outside loop mode each user pin is the inverse of its control bit
   property p_user_out;
      @(posedge hclk) disable iff (!hresetn)
      !loop_on |-> (user_output_one_n == !modem_control_register_r[ump_pkg::MCTL_USER1])
                   && (user_output_two_n == !modem_control_register_r[ump_pkg::MCTL_USER2]);
   endproperty
   a_user_out: assert property (p_user_out) else $error("user output wrong"); // [R1]
   property p_loop;
      @(posedge hclk) disable iff (!hresetn)
      loop_on |-> (user_output_one_n && user_output_two_n && rts_n);
   endproperty
   a_loop: assert property (p_loop) else $error("loop mode outputs not inactive"); // [R2]
   // Status read on the bus must carry the ring level seen at the address phase
   property p_ring_lvl;
      @(posedge hclk) disable iff (!hresetn)
      rd_msr_ahb |=> (hrdata[ump_pkg::MSR_RING] == !$past(ring_s));
   endproperty
   a_ring_lvl: assert property (p_ring_lvl) else $error("ring status bit wrong"); // [R6]
   property p_ring_flag;
      @(posedge hclk) disable iff (!hresetn) ring_rise |=> ring_trailing_edge_flag_r;
   endproperty
   a_ring_flag: assert property (p_ring_flag) else $error("ring flag not set"); // [R7]
   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      (ring_rise && ien_r[ump_pkg::IST_MSI]) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("ring interrupt missing"); // [R8]
   property p_rts;
      @(posedge hclk) disable iff (!hresetn)
      (!modem_control_register_r[ump_pkg::MCTL_RTS] || (auto_rts && rx_threshold_hit)) |-> rts_n;
   endproperty
   a_rts: assert property (p_rts) else $error("rts active wrongly"); // [R9]
   property p_mode0;
      @(posedge hclk) disable iff (!hresetn)
      (!mode1 && rx_char_held) |=> !receiver_dma_request_n;
   endproperty
   a_mode0: assert property (p_mode0) else $error("mode 0 request missing"); // [R13]
   property p_drain;
      @(posedge hclk) disable iff (!hresetn) !rx_char_held |=> receiver_dma_request_n;
   endproperty
   a_drain: assert property (p_drain) else $error("request not released"); // [R14]
   property p_drv_dis;
      @(posedge hclk) disable iff (!hresetn) !pin_read |=> driver_disable_output;
   endproperty
   a_drv_dis: assert property (p_drv_dis) else $error("driver disable low while idle"); // [R16]
   property p_clr;
      @(posedge hclk) disable iff (!hresetn)
      (msr_read && !ring_rise) |=> !ring_trailing_edge_flag_r;
   endproperty
   a_clr: assert property (p_clr) else $error("ring flag not cleared"); // [R17]
   c_ring: cover property (@(posedge hclk) disable iff (!hresetn) ring_rise ##1 irq);
   c_m1: cover property (@(posedge hclk) disable iff (!hresetn) mode1 && !receiver_dma_request_n);
   c_auto: cover property (@(posedge hclk) disable iff (!hresetn) auto_rts && rx_threshold_hit);
   c_tick: cover property (@(posedge hclk) disable iff (!hresetn) rx_tick);
endmodule
`default_nettype wire

//--- verification/ump_rx_model.sv
// Purpose: far-side model of receiver FIFO fill level and ring line
// Assumes: bench pulses push or pop for one cycle per character
// Notes: only the count is kept, no character data
`timescale 1ns/1ps
`default_nettype none
module ump_rx_model #(parameter int TRIG = 4, parameter int THR = 6) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic push,
   input wire logic pop,
   input wire logic ring_active,
   output logic ring_indicator_n,
   output logic rx_clk16,
   output logic rx_char_held,
   output logic rx_trigger_hit,
   output logic rx_threshold_hit
);
   int count_r;
   logic [1:0] div_r;
   // Count; a pop on empty is ignored, as a real FIFO would
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= 0;
         div_r <= 2'h0;
      end else begin
         count_r <= count_r + int'(push) - int'(pop && count_r > 0);
         div_r <= div_r + 2'h1;
      end
   end
   // Sixteen-times clock for an arbitrary baud
   assign rx_clk16 = div_r[1];
   assign ring_indicator_n = !ring_active; // Low while ringing
   assign rx_char_held = (count_r > 0);
   assign rx_trigger_hit = (count_r >= TRIG);
   assign rx_threshold_hit = (count_r >= THR);
endmodule
`default_nettype wire

//--- verification/test_ump_top.sv
// Purpose: register-level bench of the modem pin and DMA request block
// Assumes: zero-wait AHB-Lite slave; FIFO model trigger 4, threshold 6
// Notes: sync delays are covered by a fixed settle of eight cycles
`timescale 1ns/1ps
`default_nettype none
module test_ump_top;
   logic hclk, hresetn, hsel, hwrite, hready, cs, rdl, rdh, push, pop, ring;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, pin_addr;
   logic [7:0] pin_rdata;
   logic hreadyout, hresp, drv_dis, ring_pin_n, clk16, held, trig, thr, o1_n, o2_n, rts_n, dma_n, irq;
   int n_mismatch = 0;
   int n_tests = 0;
   ump_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .chip_select(cs), .read_strobe_low_active(rdl),
      .read_strobe_high_active(rdh), .pin_addr(pin_addr), .pin_rdata(pin_rdata),
      .driver_disable_output(drv_dis), .ring_indicator_n(ring_pin_n), .rx_clk16(clk16), .rx_char_held(held),
      .rx_trigger_hit(trig), .rx_threshold_hit(thr), .user_output_one_n(o1_n),
      .user_output_two_n(o2_n), .rts_n(rts_n), .receiver_dma_request_n(dma_n), .irq(irq));
   ump_rx_model #(.TRIG(4), .THR(6)) model_u (.hclk(hclk), .hresetn(hresetn), .push(push),
      .pop(pop), .ring_active(ring), .ring_indicator_n(ring_pin_n), .rx_clk16(clk16),
      .rx_char_held(held), .rx_trigger_hit(trig), .rx_threshold_hit(thr));
   // Single slave on the bus: its ready output is the bus ready
   assign hready = hreadyout;
   // 200 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for hready at a rising edge
   task automatic hready_edge();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 50);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask
   // One single word transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      hready_edge();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      hready_edge();
      rd = hrdata;
      cmp("hresp okay", 32'h0, {31'h0, hresp});
   endtask
   task automatic settle();
      repeat (8) @(posedge hclk);
   endtask
   // Pins are looked at one edge after the write lands, never at the launching edge
   task automatic mctl_chk(input logic [7:0] v, input logic [3:0] exp);
      ahb(1'b1, ump_pkg::ADDR_MCTL, {24'h0, v});
      @(posedge hclk);
      cmp("user1 user2 rts dma", {28'h0, exp}, {28'h0, o1_n, o2_n, rts_n, dma_n});
   endtask
   task automatic fifo(input logic up, input int n);
      repeat (n) begin
         push <= up;
         pop <= !up;
         @(posedge hclk);
      end
      push <= 1'b0;
      pop <= 1'b0;
      settle();
   endtask
   // Pin read with one strobe; the other held inactive
   task automatic pin_read(input logic hi, input logic [7:0] exp);
      cs <= 1'b1;
      pin_addr <= 3'h1;
      if (hi) begin
         rdh <= 1'b1;
      end else begin
         rdl <= 1'b0;
      end
      @(posedge hclk);
      // Read taken at this edge; strobes released by the same edge
      cs <= 1'b0;
      rdh <= 1'b0;
      rdl <= 1'b1;
      #1;
      cmp("pin_rdata", {24'h0, exp}, {24'h0, pin_rdata & 8'h44});
      cmp("driver disable reading", 32'h0, {31'h0, drv_dis});
      @(posedge hclk);
      #1;
      cmp("driver disable idle", 32'h1, {31'h0, drv_dis});
      @(posedge hclk);
   endtask
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, cs, rdh, push, pop, ring, htrans, pin_addr} = '0;
      {haddr, hwdata} = '0;
      rdl = 1'b1;
      hsize = 3'h2;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cmp("reset outs", 32'h1F, {27'h0, o1_n, o2_n, rts_n, dma_n, drv_dis});
      ahb(1'b0, ump_pkg::ADDR_MCTL, 32'h0);
      cmp("mctl reset", {24'h0, ump_pkg::MCTL_RST}, rd & 32'hFF);
      ahb(1'b1, 8'h40, 32'hFF);
      ahb(1'b0, 8'h40, 32'h0);
      cmp("unmapped", ump_pkg::UNMAPPED, rd);
      mctl_chk(8'h0E, 4'h1);
      mctl_chk(8'h1E, 4'hF);
      mctl_chk(8'h0A, 4'h9);
      mctl_chk(8'h06, 4'h5);
      ahb(1'b1, ump_pkg::ADDR_FCR, 32'h01);
      mctl_chk(8'h22, 4'hD);
      fifo(1'b1, 6);
      cmp("auto rts", 32'h1, {31'h0, rts_n});
      fifo(1'b0, 6);
      cmp("dma empty", 32'h1, {31'h0, dma_n});
      ahb(1'b1, ump_pkg::ADDR_FCR, 32'h08);
      fifo(1'b1, 1);
      cmp("char mode dma", 32'h0, {31'h0, dma_n});
      fifo(1'b0, 1);
      ahb(1'b1, ump_pkg::ADDR_FCR, 32'h09);
      fifo(1'b1, 1);
      cmp("mode1 below trig", 32'h1, {31'h0, dma_n});
      fifo(1'b1, 3);
      cmp("mode1 at trig", 32'h0, {31'h0, dma_n});
      fifo(1'b0, 2);
      cmp("mode1 draining", 32'h0, {31'h0, dma_n});
      fifo(1'b0, 2);
      cmp("mode1 empty", 32'h1, {31'h0, dma_n});
      ahb(1'b0, ump_pkg::ADDR_IST, 32'h0);
      cmp("dma status", 32'h2, rd & 32'h2);
      ahb(1'b1, ump_pkg::ADDR_ICLR, 32'h3);
      ahb(1'b1, ump_pkg::ADDR_IEN, 32'h1);
      ring <= 1'b1;
      settle();
      pin_read(1'b0, 8'h40);
      ring <= 1'b0;
      settle();
      cmp("irq ring end", 32'h1, {31'h0, irq});
      ahb(1'b0, ump_pkg::ADDR_MSR, 32'h0);
      cmp("msr flag", 32'h04, rd & 32'h44);
      pin_read(1'b1, 8'h00);
      ahb(1'b1, ump_pkg::ADDR_ICLR, 32'h1);
      ahb(1'b1, ump_pkg::ADDR_IEN, 32'h0);
      ring <= 1'b1;
      settle();
      ring <= 1'b0;
      settle();
      cmp("irq masked", 32'h0, {31'h0, irq});
      ahb(1'b0, ump_pkg::ADDR_IST, 32'h0);
      cmp("ring status", 32'h1, rd & 32'h1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
